// >>> dacrb_defines.vh
`ifndef DACRB_DEFINES_VH
`define DACRB_DEFINES_VH

// ****************************************
// frame layout
// ****************************************
`define DACRB_FRAME_BITS 5'h18
`define DACRB_CMD_HI 23
`define DACRB_CMD_LO 16
`define DACRB_FIELD_HI 15
`define DACRB_FIELD_LO 7

// ****************************************
// special function codes (mode 00 + address)
// ****************************************
`define DACRB_CMD_NOP 8'h00
`define DACRB_CMD_READBACK 8'h05
`define DACRB_CMD_BANK_LOW 8'h06
`define DACRB_CMD_BANK_HIGH 8'h07
`define DACRB_CMD_BANK_BLOCK 8'h0B
`define DACRB_CMD_GPIO_CFG 8'h0D

// ****************************************
// readback field codes
// ****************************************
`define DACRB_RB_CHAN_FIRST 6'h08
`define DACRB_RB_CHAN_LAST 6'h17
`define DACRB_RB_CONTROL 8'h01
`define DACRB_RB_OFFSET_ZERO 8'h02
`define DACRB_RB_OFFSET_ONE 8'h03
`define DACRB_RB_BANK_LOW 8'h06
`define DACRB_RB_BANK_HIGH 8'h07
`define DACRB_RB_GPIO 8'h0B

// ****************************************
// lookup selectors for externally held registers
// ****************************************
`define DACRB_SEL_INPUT_PRIMARY 3'h0
`define DACRB_SEL_INPUT_ALTERNATE 3'h1
`define DACRB_SEL_OFFSET_TRIM 3'h2
`define DACRB_SEL_GAIN_TRIM 3'h3
`define DACRB_SEL_CONTROL 3'h4
`define DACRB_SEL_OFFSET_ZERO 3'h5
`define DACRB_SEL_OFFSET_ONE 3'h6
`define DACRB_SEL_NONE 3'h7

// ****************************************
// reset values
// ****************************************
`define DACRB_BANK_RESET 8'h00

`endif

// >>> dacrb_readback.v
// What this block does
// - top bits 000/001/010/011 select input primary, input alternate, offset trim or gain trim, with channel code 001000..010111 in bits twelve to seven.
// - with the top field bit set, code 01 picks control, 02/03 the offset data registers, 06/07 the bank select registers.
// - code 1 then 00001011 returns the general-purpose pin level in bit zero.
// - bits six to zero of a readback request never change which register is returned.
// - bank select low bits map to channels 7..0, high bits to 15..8; a cleared bit selects the first secondary register.
// - a set bank select bit selects the alternate secondary register.
// - a readback request frame is followed by a second frame during which the data is shifted out.
// - a block write of zeros clears every bank bit, of ones sets every bank bit.
`include "dacrb_defines.vh"

module dacrb_readback (
   input wire core_clk,
   input wire rst,
   input wire sclk,
   input wire sync_n,
   input wire sdi,
   output wire sdo,
   input wire gpio_in,
   output wire gpio_out,
   output wire gpio_oe,
   output wire [15:0] bank_use_second,
   output wire lookup_req,
   output wire [2:0] lookup_sel,
   output wire [3:0] lookup_chan,
   input wire [15:0] lookup_data
);

   // ****************************************
   // readback field decode
   // ****************************************
   // returns {valid, selector[2:0], chan[3:0]}; frame bits six to zero never reach here
   function [7:0] rb_decode;
      input [8:0] field;
      reg [5:0] code;
      begin
         code = field[5:0];
         rb_decode = {1'b0, `DACRB_SEL_NONE, 4'h0};
         if (!field[8]) begin
            // trim types share the channel code of the input registers
            if (code >= `DACRB_RB_CHAN_FIRST && code <= `DACRB_RB_CHAN_LAST) begin
               rb_decode = {1'b1, field[8:6], code[3:0] - 4'h8};
            end
         end else begin
            case (field[7:0])
               `DACRB_RB_CONTROL: rb_decode = {1'b1, `DACRB_SEL_CONTROL, 4'h0};
               `DACRB_RB_OFFSET_ZERO: rb_decode = {1'b1, `DACRB_SEL_OFFSET_ZERO, 4'h0};
               `DACRB_RB_OFFSET_ONE: rb_decode = {1'b1, `DACRB_SEL_OFFSET_ONE, 4'h0};
               default: rb_decode = {1'b0, `DACRB_SEL_NONE, 4'h0};
            endcase
         end
      end
   endfunction

   // returns {hit, data}; only the bank select registers held inside this block and the pin level hit
   function [16:0] local_read;
      input [7:0] code;
      input [7:0] low;
      input [7:0] high;
      input pin;
      begin
         case (code)
            `DACRB_RB_BANK_LOW: local_read = {1'b1, 8'h00, low};
            `DACRB_RB_BANK_HIGH: local_read = {1'b1, 8'h00, high};
            `DACRB_RB_GPIO: local_read = {1'b1, 15'h0000, pin};
            default: local_read = {1'b0, 16'h0000};
         endcase
      end
   endfunction

   // ****************************************
   // frame capture
   // ****************************************
   reg sclk_d_r;
   reg sync_d_r;
   reg [23:0] rx_r;
   reg [4:0] cnt_r;
   reg [23:0] tx_r;
   reg [15:0] rb_data_r;
   reg fetch_r;
   reg [2:0] sel_r;
   reg [3:0] chan_r;
   reg [7:0] bank_low_r;
   reg [7:0] bank_high_r;
   reg gpio_dir_r;
   reg gpio_val_r;

   wire sclk_rise = sclk && !sclk_d_r;
   wire frame_start = !sync_n && sync_d_r;
   wire frame_end = sync_n && !sync_d_r;
   wire full_word = (cnt_r == `DACRB_FRAME_BITS);

   // ****************************************
   // frame decode
   // ****************************************
   wire frame_ok = frame_end && full_word;
   wire [7:0] cmd = rx_r[`DACRB_CMD_HI:`DACRB_CMD_LO];
   wire is_readback = frame_ok && (cmd == `DACRB_CMD_READBACK);
   // rx_r[6:0] deliberately not part of the field
   wire [8:0] field = rx_r[`DACRB_FIELD_HI:`DACRB_FIELD_LO];
   wire [7:0] dec = rb_decode(field);
   wire [16:0] loc = local_read(field[7:0], bank_low_r, bank_high_r, gpio_in);
   // with the top field bit clear the code is a channel request instead
   wire loc_hit = field[8] && loc[16];

   // saturates past a full word so that long frames never look complete
   localparam [4:0] CNT_TOP = 5'h1f;

   always @(posedge core_clk) begin
      if (rst) begin
         sclk_d_r <= 1'b0;
         sync_d_r <= 1'b1;
         rx_r <= 24'h00_0000;
         cnt_r <= 5'h00;
      end else begin
         sclk_d_r <= sclk;
         sync_d_r <= sync_n;
         if (sync_n) begin
            cnt_r <= 5'h00;
         end else if (sclk_rise) begin
            rx_r <= {rx_r[22:0], sdi};
            if (cnt_r != CNT_TOP) begin
               cnt_r <= cnt_r + 5'h01;
            end
         end
      end
   end

   // ****************************************
   // command execution
   // ****************************************
   // short or long frames are dropped whole, so a glitch cannot corrupt state
   always @(posedge core_clk) begin
      if (rst) begin
         bank_low_r <= `DACRB_BANK_RESET;
         bank_high_r <= `DACRB_BANK_RESET;
      end else if (frame_ok) begin
         case (cmd)
            `DACRB_CMD_BANK_LOW: bank_low_r <= rx_r[7:0];
            `DACRB_CMD_BANK_HIGH: bank_high_r <= rx_r[7:0];
            `DACRB_CMD_BANK_BLOCK: begin
               // any byte is copied to both halves; only 00 and ff are meaningful
               bank_low_r <= rx_r[7:0];
               bank_high_r <= rx_r[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // pin configuration
   // ****************************************
   // direction and level always arrive together in one frame
   always @(posedge core_clk) begin
      if (rst) begin
         gpio_dir_r <= 1'b0;
         gpio_val_r <= 1'b0;
      end else if (frame_ok && cmd == `DACRB_CMD_GPIO_CFG) begin
         gpio_dir_r <= rx_r[1];
         gpio_val_r <= rx_r[0];
      end
   end

   // ****************************************
   // readback request
   // ****************************************
   // external values are taken in the same cycle as the request pulse
   always @(posedge core_clk) begin
      if (rst) begin
         rb_data_r <= 16'h0000;
         fetch_r <= 1'b0;
         sel_r <= `DACRB_SEL_NONE;
         chan_r <= 4'h0;
      end else begin
         fetch_r <= 1'b0;
         if (fetch_r) begin
            rb_data_r <= lookup_data;
         end
         if (frame_start) begin
            rb_data_r <= 16'h0000;
         end
         if (is_readback) begin
            rb_data_r <= 16'h0000;
            if (dec[7]) begin
               fetch_r <= 1'b1;
               sel_r <= dec[6:4];
               chan_r <= dec[3:0];
            end else if (loc_hit) begin
               rb_data_r <= loc[15:0];
            end
         end
      end
   end

   // ****************************************
   // readback shifter
   // ****************************************
   // data sits in the low 16 bits of the returned word
   always @(posedge core_clk) begin
      if (rst) begin
         tx_r <= 24'h00_0000;
      end else if (frame_start) begin
         tx_r <= {8'h00, rb_data_r};
      end else if (!sync_n && sclk_rise) begin
         tx_r <= {tx_r[22:0], 1'b0};
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // the pad driver itself sits outside; only its controls leave here
   assign sdo = tx_r[23];
   assign gpio_out = gpio_val_r;
   assign gpio_oe = gpio_dir_r;
   assign bank_use_second = {bank_high_r, bank_low_r};
   assign lookup_req = fetch_r;
   assign lookup_sel = sel_r;
   assign lookup_chan = chan_r;

endmodule // dacrb_readback

// >>> dacrb_host.sv
// ****
// spi host
// ****
module dacrb_host (
   input wire core_clk,
   input wire sdo,
   output logic sclk,
   output logic sync_n,
   output logic sdi
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      sdi = 1'b0;
   end
   // clock stands still outside frames
   task automatic xfer(input logic [23:0] w, output logic [23:0] r);
      @(negedge core_clk) sync_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi = w[i];
         repeat (2) @(negedge core_clk);
         r[i] = sdo;
         sclk = 1'b1;
         repeat (2) @(negedge core_clk);
         sclk = 1'b0;
      end
      repeat (2) @(negedge core_clk);
      sync_n = 1'b1;
      sdi = ~sdi;
      repeat (4) @(negedge core_clk);
   endtask
endmodule // dacrb_host

// >>> dacrb_checker.sv
// ****
// port checks
// ****
module dacrb_checker (
   input wire core_clk,
   input wire rst,
   input wire sclk,
   input wire sync_n,
   input wire sdo,
   input wire gpio_out,
   input wire gpio_oe,
   input wire [15:0] bank_use_second,
   input wire lookup_req,
   input wire [2:0] lookup_sel,
   input wire [3:0] lookup_chan
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // bank, pin and lookup state move only right after a frame ends; sdo also moves on sclk rises inside a frame
   a_bank_at_end: assert property ($changed(bank_use_second) && !$past(rst)
      |-> $past(sync_n) && !$past(sync_n, 2)) else $error("bank moved");
   a_gpio_at_end: assert property ($changed({gpio_out, gpio_oe}) && !$past(rst)
      |-> $past(sync_n) && !$past(sync_n, 2)) else $error("gpio moved");
   a_req_at_end: assert property (lookup_req
      |-> $past(sync_n) && !$past(sync_n, 2)) else $error("late lookup");
   a_req_one_pulse: assert property (lookup_req |=> !lookup_req) else $error("long req");
   a_sel_in_range: assert property (lookup_req |-> lookup_sel != 3'h7) else $error("bad sel");
   a_chan_zero_fixed: assert property (lookup_req && lookup_sel[2]
      |-> lookup_chan == 4'h0) else $error("bad chan");
   a_sdo_lead_zero: assert property ($fell(sync_n) |-> ##2 !sdo) else $error("lead bit");
   a_sdo_shift_time: assert property (!sync_n && $changed(sdo)
      |-> ($past(sclk) && !$past(sclk, 2)) || (!$past(sync_n) && $past(sync_n, 2)))
      else $error("sdo moved");
endmodule // dacrb_checker
bind dacrb_readback dacrb_checker dacrb_checker_i (.core_clk(core_clk), .rst(rst),
   .sclk(sclk), .sync_n(sync_n), .sdo(sdo), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
   .bank_use_second(bank_use_second), .lookup_req(lookup_req), .lookup_sel(lookup_sel),
   .lookup_chan(lookup_chan));

// >>> test_dacrb_readback.sv
// ****
// bench
// ****
module test_dacrb_readback;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst = 1'b1, gpio_in = 1'b0, sclk, sync_n, sdi, sdo;
   logic gpio_out, gpio_oe, lookup_req;
   logic [15:0] bank_use_second, b, lookup_data = 16'h0000;
   logic [2:0] lookup_sel;
   logic [3:0] lookup_chan;
   logic [23:0] r;
   logic [8:0] rsv [4] = '{9'h104, 9'h108, 9'h109, 9'h10a};
   integer seed = 87039, bad_count = 0, cmp_count = 0, cyc = 0;
   dacrb_readback dacrb_readback_i (.core_clk(core_clk), .rst(rst), .sclk(sclk), .sync_n(sync_n),
      .sdi(sdi), .sdo(sdo), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .bank_use_second(bank_use_second), .lookup_req(lookup_req), .lookup_sel(lookup_sel),
      .lookup_chan(lookup_chan), .lookup_data(lookup_data));
   dacrb_host dacrb_host_i (.core_clk(core_clk), .sdo(sdo), .sclk(sclk), .sync_n(sync_n), .sdi(sdi));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   function automatic logic [15:0] ext(input logic [2:0] s, input logic [3:0] c);
      return {s, 5'h15, c, ~c};
   endfunction
   always @(negedge core_clk) begin
      lookup_data <= ext(lookup_sel, lookup_chan);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         close_out;
      end
   end
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      dacrb_host_i.xfer({c, d}, r);
   endtask
   task automatic rd(input logic [8:0] f, input logic [6:0] lo, input logic [15:0] e);
      dacrb_host_i.xfer({8'h05, f, lo}, r);
      dacrb_host_i.xfer(24'h00_0000, r);
      chk("readback", {8'h00, e}, r);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      chk("bank", 24'h00_0000, bank_use_second);
      wr(8'h0d, 16'h0003);
      for (int k = 0; k < 8; k++) begin
         b = $random(seed);
         wr(8'h06, b[7:0]);
         wr(8'h07, b[15:8]);
         rd(9'h106, b[6:0], b[7:0]);
         rd(9'h107, b[14:8], b[15:8]);
         rd({1'b0, k[1:0], 6'h08 + b[3:0]}, b[13:7], ext(k[1:0], b[3:0]));
         rd(9'(9'h101 + k % 3), b[12:6], ext(3'(4 + k % 3), 4'h0));
         gpio_in = b[9];
         rd(9'h10b, 7'h00, {15'h0000, b[9]});
         rd(rsv[k[1:0]], b[6:0], 16'h0000);
         chk("bank", b, bank_use_second);
      end
      wr(8'h0b, 16'h0000);
      chk("bank", 24'h00_0000, bank_use_second);
      wr(8'h0b, 16'h00ff);
      chk("bank", 24'h00_ffff, bank_use_second);
      chk("pin", 24'h00_0003, {gpio_oe, gpio_out});
      wr(8'h0d, 16'h0002);
      chk("pin", 24'h00_0002, {gpio_oe, gpio_out});
      close_out;
   end
endmodule // test_dacrb_readback
